// >>> rtl/zol_regs.svh
// Constants of the zero-overhead loop controller.
// Assumes inclusion by its bare name from the rtl/ folder.
`ifndef ZOL_REGS_SVH
`define ZOL_REGS_SVH

// ****************************************************************
// CSR map of the loop registers
// ****************************************************************
`define ZOL_CSR_BASE 12'hcc0
`define ZOL_CSR_SET_STRIDE 12'h004
`define ZOL_FIELD_START 2'h0
`define ZOL_FIELD_END 2'h1
`define ZOL_FIELD_COUNT 2'h2

// ****************************************************************
// Widths, positions and reset values
// ****************************************************************
`define ZOL_XLEN 32
`define ZOL_IMM_W 12
`define ZOL_WORD_SHIFT 2
`define ZOL_INSTR_BYTES 32'h0000_0004
`define ZOL_RST_ADDR 32'h0000_0000
`define ZOL_RST_COUNT 32'h0000_0000

`endif

// >>> rtl/zol_pkg.sv
// Types shared by the zero-overhead loop controller files.
// Assumes zol_regs.svh sits beside it.
`include "zol_regs.svh"

package zol_pkg;
    typedef logic [`ZOL_XLEN-1:0] zol_word_t;

    typedef enum logic [1:0] {
        ZOL_OP_START = 2'h0,
        ZOL_OP_END = 2'h1,
        ZOL_OP_COUNT = 2'h2,
        ZOL_OP_SETUP = 2'h3
    } zol_op_e;

    typedef enum logic [1:0] {
        ZOL_RSP_IDLE = 2'h0,
        ZOL_RSP_READ = 2'h1,
        ZOL_RSP_TRAP = 2'h2
    } zol_rsp_e;
endpackage

// >>> rtl/zol_csr_if.sv
// Interface between the loop controller and its CSR address decoder.
// Assumes both ends run on the same clock; it carries no state.
`timescale 1ns/1ns

interface zol_csr_if;
    logic [11:0] addr;
    logic hit;
    logic set;
    logic [1:0] field;

    modport dec (input addr, output hit, set, field);
    modport ctl (output addr, input hit, set, field);
endinterface

// >>> rtl/zol_csr_decode.sv
// CSR address decoder for the loop register sets.
// Assumes a purely combinational path; the caller registers results.
`timescale 1ns/1ns
`include "zol_regs.svh"

module zol_csr_decode
(
    zol_csr_if.dec bus // Address in, set and field out.
);
    logic [11:0] off;

    always_comb
    begin
        off = bus.addr - `ZOL_CSR_BASE;
        bus.set = off[2];
        bus.field = off[1:0];
        // The unused slot in each set of four is left unmapped.
        if (bus.addr < `ZOL_CSR_BASE)
        begin
            bus.hit = 1'b0;
        end
        else if (off >= (`ZOL_CSR_SET_STRIDE << 1))
        begin
            bus.hit = 1'b0;
        end
        else if (off[1:0] == 2'h3)
        begin
            bus.hit = 1'b0;
        end
        else
        begin
            bus.hit = 1'b1;
        end
    end
endmodule

// >>> rtl/zol_ctrl.sv
// Zero-overhead loop controller: two loop register sets, setup
// instruction execution, end-of-body detection and CSR read-back.
// Assumes the core decoder classifies instructions and supplies pc.
// How it works
// RL1: Placement and content mistakes are not detected; no exception results.
// RL2: Software aligns start, end and setup instructions on 32-bit words.
// RL3: Software makes end exceed start and point past the last body instr.
// RL4: Software keeps every loop body at least three instructions long.
// RL5: Loop 1 is outer; its end lies eight bytes past loop 0 end.
// RL6: Software enters a loop only at its start address.
// RL7: Software never changes a loop's registers inside that loop's body.
// RL8: Bodies avoid compressed, jumps, branches, fences, most privileged ops.
// RL9: Start, end, count and combined setup, each immediate and register form.
// RL10: All loop registers read back through custom read-only CSRs.
// RL11: Any CSR write to a loop register raises an illegal instruction.
// RL12: Register setup forms write loop registers, used to restore state.
// RL13: Loop and other custom extensions exist only when enabled by parameter.
// RL14: Event load exists only when the cluster parameter is one.
// RL15: Custom operands are signed and immediates sign-extended.
// RL16: Two loop sets; loop 0 wins and acts as the inner loop.
// RL17: Last body instruction decrements count, jumps back with no stall; jump_o is registered, so each redirect costs one killed fetch.
// RL18: Count reaching zero falls through at end; loop becomes inactive.
`timescale 1ns/1ns
`include "zol_regs.svh"

module zol_ctrl #(
    parameter bit CUSTOM_EXT_ENABLE = 1'b1,
    parameter bit CLUSTER_EXT_ENABLE = 1'b0
)
(
    input wire logic clk_i, // Core clock, 10 MHz.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire logic en_i, // Clock enable; low freezes all state.
    input wire logic setup_valid_i, // Loop setup instruction executes.
    input wire logic [1:0] setup_op_i, // Setup kind, zol_pkg::zol_op_e.
    input wire logic setup_reg_form_i, // High for the register form.
    input wire logic setup_loop_i, // Loop set addressed by the setup.
    input wire logic [31:0] setup_pc_i, // Address of the setup instr.
    input wire logic [11:0] setup_imm_i, // Immediate field of the setup.
    input wire logic [31:0] setup_rs1_i, // Register operand of the setup.
    input wire logic [11:0] setup_uimm_i, // Second immediate (combined).
    input wire logic fetch_valid_i, // A body instruction is fetched.
    input wire logic [31:0] fetch_pc_i, // Address of that instruction.
    input wire logic csr_valid_i, // CSR instruction executes.
    input wire logic csr_write_i, // That CSR access writes.
    input wire logic [11:0] csr_addr_i, // CSR address.
    input wire logic custom_valid_i, // Other custom instr executes.
    input wire logic elw_valid_i, // Event load instruction executes.
    output logic jump_o, // Redirect fetch to jump_addr_o.
    output logic [31:0] jump_addr_o, // Loop start to fetch next.
    output logic csr_hit_o, // Read answered by a loop register.
    output logic [31:0] csr_rdata_o, // Read data of the loop register.
    output logic illegal_o // Illegal instruction exception.
);
    localparam int NLOOP = 2;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic zol_pkg::zol_word_t sext_imm(
        input logic [`ZOL_IMM_W-1:0] imm
    );
        sext_imm = {{(`ZOL_XLEN-`ZOL_IMM_W){imm[`ZOL_IMM_W-1]}}, imm};
    endfunction

    function automatic zol_pkg::zol_word_t pc_target(
        input zol_pkg::zol_word_t pc,
        input logic [`ZOL_IMM_W-1:0] imm
    );
        // Word offsets are signed so loops may sit before the setup.
        pc_target = pc + (sext_imm(imm) << `ZOL_WORD_SHIFT); // RL15
    endfunction

    // ****************************************************************
    // Loop register sets
    // ****************************************************************
    zol_pkg::zol_word_t start_q [NLOOP];
    zol_pkg::zol_word_t end_q [NLOOP];
    zol_pkg::zol_word_t count_q [NLOOP];
    zol_pkg::zol_word_t next_start [NLOOP];
    zol_pkg::zol_word_t next_end [NLOOP];
    zol_pkg::zol_word_t next_count [NLOOP];
    logic next_jump;
    zol_pkg::zol_word_t next_jump_addr;
    zol_pkg::zol_word_t setup_val;
    logic loop_hit [NLOOP];
    logic take [NLOOP];
    logic fetch_done;
    zol_pkg::zol_op_e op;

    // No range or alignment checks are built; the adders they would
    // need cost more than the misuse they would catch.
    always_comb // RL1
    begin
        op = zol_pkg::zol_op_e'(setup_op_i);
        for (int i = 0; i < NLOOP; i++)
        begin
            next_start[i] = start_q[i];
            next_end[i] = end_q[i];
            next_count[i] = count_q[i];
            loop_hit[i] = (count_q[i] != `ZOL_RST_COUNT)
                && (fetch_pc_i + `ZOL_INSTR_BYTES == end_q[i]);
            take[i] = 1'b0;
        end
        next_jump = 1'b0;
        next_jump_addr = jump_addr_o;
        fetch_done = 1'b0;
        // Loop 0 is searched first, so it is the inner loop.
        for (int i = 0; i < NLOOP; i++) // RL16
        begin
            if (CUSTOM_EXT_ENABLE && fetch_valid_i && loop_hit[i]
                && !fetch_done)
            begin
                take[i] = 1'b1;
                fetch_done = 1'b1;
            end
        end
        for (int i = 0; i < NLOOP; i++)
        begin
            if (take[i])
            begin
                next_count[i] = count_q[i] - 32'h0000_0001; // RL17
                // Count one falls through to the end address.
                if (count_q[i] != 32'h0000_0001) // RL18
                begin
                    next_jump = 1'b1; // RL17
                    next_jump_addr = start_q[i];
                end
            end
        end
        setup_val = setup_reg_form_i ? setup_rs1_i
            : pc_target(setup_pc_i, setup_imm_i); // RL12
        if (CUSTOM_EXT_ENABLE && setup_valid_i) // RL13
        begin
            case (op) // RL9
                zol_pkg::ZOL_OP_START:
                begin
                    next_start[setup_loop_i] = setup_val;
                end
                zol_pkg::ZOL_OP_END:
                begin
                    next_end[setup_loop_i] = setup_val;
                end
                zol_pkg::ZOL_OP_COUNT:
                begin
                    next_count[setup_loop_i] = setup_reg_form_i
                        ? setup_rs1_i : sext_imm(setup_imm_i); // RL15
                end
                default:
                begin
                    next_start[setup_loop_i] = setup_pc_i
                        + `ZOL_INSTR_BYTES;
                    next_end[setup_loop_i] =
                        pc_target(setup_pc_i, setup_uimm_i);
                    next_count[setup_loop_i] = setup_reg_form_i
                        ? setup_rs1_i : sext_imm(setup_imm_i); // RL15
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < NLOOP; i++)
            begin
                start_q[i] <= `ZOL_RST_ADDR;
                end_q[i] <= `ZOL_RST_ADDR;
                count_q[i] <= `ZOL_RST_COUNT;
            end
            jump_o <= 1'b0;
            jump_addr_o <= `ZOL_RST_ADDR;
        end
        else if (en_i)
        begin
            for (int i = 0; i < NLOOP; i++)
            begin
                start_q[i] <= next_start[i];
                end_q[i] <= next_end[i];
                count_q[i] <= next_count[i];
            end
            jump_o <= next_jump;
            jump_addr_o <= next_jump_addr;
        end
    end

    // ****************************************************************
    // CSR read-back and illegal instruction detection
    // ****************************************************************
    zol_csr_if csr_bus ();

    zol_csr_decode u_dec (
        .bus(csr_bus)
    );

    assign csr_bus.addr = csr_addr_i;

    logic next_csr_hit;
    zol_pkg::zol_word_t next_csr_rdata;
    logic next_illegal;
    zol_pkg::zol_rsp_e rsp;

    always_comb
    begin
        rsp = zol_pkg::ZOL_RSP_IDLE;
        if (csr_valid_i && csr_bus.hit && CUSTOM_EXT_ENABLE)
        begin
            rsp = csr_write_i ? zol_pkg::ZOL_RSP_TRAP // RL11
                : zol_pkg::ZOL_RSP_READ; // RL10
        end
        next_csr_hit = 1'b0;
        next_csr_rdata = `ZOL_RST_COUNT;
        next_illegal = 1'b0;
        case (rsp)
            zol_pkg::ZOL_RSP_READ:
            begin
                next_csr_hit = 1'b1;
                if (csr_bus.field == `ZOL_FIELD_START)
                begin
                    next_csr_rdata = start_q[csr_bus.set]; // RL10
                end
                else if (csr_bus.field == `ZOL_FIELD_END)
                begin
                    next_csr_rdata = end_q[csr_bus.set];
                end
                else
                begin
                    next_csr_rdata = count_q[csr_bus.set];
                end
            end
            zol_pkg::ZOL_RSP_TRAP:
            begin
                next_illegal = 1'b1; // RL11
            end
            default:
            begin
                next_illegal = 1'b0;
            end
        endcase
        // With the extension absent its instructions do not exist.
        if (!CUSTOM_EXT_ENABLE && (setup_valid_i || custom_valid_i))
        begin
            next_illegal = 1'b1; // RL13
        end
        if (!CLUSTER_EXT_ENABLE && elw_valid_i)
        begin
            next_illegal = 1'b1; // RL14
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            csr_hit_o <= 1'b0;
            csr_rdata_o <= `ZOL_RST_COUNT;
            illegal_o <= 1'b0;
        end
        else if (en_i)
        begin
            csr_hit_o <= next_csr_hit;
            csr_rdata_o <= next_csr_rdata;
            illegal_o <= next_illegal;
        end
    end
endmodule

// >>> tb/zol_assertions.sv
// Concurrent checks on the ports of the loop controller.
// Assumes it is bound into every instance of zol_ctrl.
`timescale 1ns/1ns

module zol_assertions #(
    parameter bit CUSTOM_EXT_ENABLE = 1'b1,
    parameter bit CLUSTER_EXT_ENABLE = 1'b0
)
(
    input wire logic clk_i, // Core clock.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire logic en_i, // Clock enable.
    input wire logic setup_valid_i, // Setup executes.
    input wire logic fetch_valid_i, // Fetch taken.
    input wire logic csr_valid_i, // CSR access.
    input wire logic csr_write_i, // CSR write.
    input wire logic [11:0] csr_addr_i, // CSR address.
    input wire logic custom_valid_i, // Other custom instruction.
    input wire logic elw_valid_i, // Event load.
    input wire logic jump_o, // Redirect.
    input wire logic csr_hit_o, // Read answered.
    input wire logic [31:0] csr_rdata_o, // Read data.
    input wire logic illegal_o // Trap.
);
    logic lp;

    // Six mapped loop registers; the fourth slot of each set is a hole.
    assign lp = csr_addr_i[11:3] == 9'h198 && csr_addr_i[1:0] != 2'h3;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    wr_trap_a: assert property (
        en_i && csr_valid_i && csr_write_i && lp && CUSTOM_EXT_ENABLE
        |=> illegal_o) else $error("loop register write not trapped");
    rd_hit_a: assert property (
        en_i && csr_valid_i && !csr_write_i && lp && CUSTOM_EXT_ENABLE
        |=> csr_hit_o && !illegal_o) else $error("loop read not answered");
    quiet_miss_a: assert property (
        en_i && csr_valid_i && !lp |=> !csr_hit_o && csr_rdata_o == 32'h0)
        else $error("foreign address answered");
    // A low enable freezes the outputs, so only look after enabled edges.
    hit_cause_a: assert property (
        csr_hit_o && $past(en_i) |-> $past(csr_valid_i && !csr_write_i))
        else $error("hit without a read");
    elw_trap_a: assert property (
        en_i && elw_valid_i && !CLUSTER_EXT_ENABLE |=> illegal_o)
        else $error("event load not trapped");
    ext_trap_a: assert property (
        en_i && (custom_valid_i || setup_valid_i) && !CUSTOM_EXT_ENABLE
        |=> illegal_o) else $error("disabled extension not trapped");
    trap_cause_a: assert property (
        illegal_o && $past(en_i) |-> $past(csr_valid_i || elw_valid_i
        || custom_valid_i || setup_valid_i)) else $error("stray trap");
    jump_cause_a: assert property (
        jump_o && $past(en_i) |-> $past(fetch_valid_i))
        else $error("jump without a fetch");
    jump_pulse_a: assert property (
        jump_o && en_i |=> !jump_o) else $error("jump longer than a cycle");
endmodule

// >>> tb/zol_stream.sv
// Instruction stream model: fetches word by word and follows redirects.
// Assumes the controller redirects one cycle after the last body fetch.
`timescale 1ns/1ns

module zol_stream
(
    input wire logic clk_i, // Core clock.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire logic go_i, // Start a run at from_i.
    input wire logic [31:0] from_i, // First address fetched.
    input wire logic [31:0] stop_i, // Address that ends the run.
    input wire logic jump_i, // Redirect request.
    input wire logic [31:0] jump_addr_i, // Redirect target.
    output logic fetch_valid_o, // Fetch taken.
    output logic [31:0] fetch_pc_o, // Its address.
    output logic busy_o, // Run in progress.
    output logic [7:0] jumps_o // Redirects followed.
);
    // The fetch after the last body word is killed by the redirect.
    assign fetch_valid_o = busy_o && fetch_pc_o != stop_i && !jump_i;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_o <= 1'b0;
            fetch_pc_o <= 32'h0;
            jumps_o <= 8'h0;
        end
        else if (go_i)
        begin
            busy_o <= 1'b1;
            fetch_pc_o <= from_i;
            jumps_o <= 8'h0;
        end
        else if (busy_o && jump_i)
        begin
            fetch_pc_o <= jump_addr_i;
            jumps_o <= jumps_o + 8'h1;
        end
        else if (busy_o && fetch_pc_o != stop_i)
            fetch_pc_o <= fetch_pc_o + 32'h4;
        else
        begin
            busy_o <= 1'b0;
            // Idle address keeps changing so no stale value looks valid.
            fetch_pc_o <= ~fetch_pc_o;
        end
    end
endmodule

// >>> tb/tb.sv
// Self-checking bench of the loop controller with the stream model.
// Assumes rtl/ on the include path.
`timescale 1ns/1ns

module tb;
    logic clk_i, rst_n_i, en_i, setup_valid_i, setup_reg_form_i;
    logic setup_loop_i, fetch_valid_i, csr_valid_i, csr_write_i;
    logic custom_valid_i, elw_valid_i, jump_o, csr_hit_o, illegal_o;
    logic off_ill, go, busy;
    logic [1:0] setup_op_i;
    logic [11:0] setup_imm_i, setup_uimm_i, csr_addr_i;
    logic [31:0] setup_pc_i, setup_rs1_i, fetch_pc_i, jump_addr_o;
    logic [31:0] csr_rdata_o, from, stop;
    logic [7:0] jumps;
    int error_cnt, checks;

    zol_ctrl #(.CUSTOM_EXT_ENABLE(1'b1), .CLUSTER_EXT_ENABLE(1'b1))
        zol_ctrl_i (.*);
    // Second copy with every extension off, to see the refusals.
    zol_ctrl #(.CUSTOM_EXT_ENABLE(1'b0), .CLUSTER_EXT_ENABLE(1'b0))
        zol_ctrl_off_i (.*, .jump_o(), .jump_addr_o(), .csr_hit_o(),
        .csr_rdata_o(), .illegal_o(off_ill));
    zol_stream zol_stream_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go),
        .from_i(from), .stop_i(stop), .jump_i(jump_o),
        .jump_addr_i(jump_addr_o), .fetch_valid_o(fetch_valid_i),
        .fetch_pc_o(fetch_pc_i), .busy_o(busy), .jumps_o(jumps));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ****************
    // Tasks
    // ****************
    task conclude;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task cmp(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask

    task setup(input logic [1:0] op, input logic rf, input logic lp,
        input logic [31:0] pc, input logic [11:0] imm,
        input logic [31:0] rs1, input logic [11:0] uimm);
        @(posedge clk_i);
        setup_valid_i <= 1'b1;
        {setup_op_i, setup_reg_form_i, setup_loop_i} <= {op, rf, lp};
        {setup_pc_i, setup_imm_i, setup_rs1_i} <= {pc, imm, rs1};
        setup_uimm_i <= uimm;
        @(posedge clk_i);
        setup_valid_i <= 1'b0;
    endtask

    // Control bits: csr valid, write, enable, event load, custom.
    task req(input logic [11:0] a, input logic [4:0] c,
        input logic [31:0] d, input logic [2:0] fl);
        @(posedge clk_i);
        {csr_valid_i, csr_write_i, en_i, elw_valid_i, custom_valid_i} <= c;
        csr_addr_i <= a;
        @(posedge clk_i);
        {csr_valid_i, csr_write_i, en_i, elw_valid_i, custom_valid_i} <= 5'h4;
        @(negedge clk_i);
        cmp(d, csr_rdata_o);
        cmp({29'h0, fl}, {29'h0, csr_hit_o, illegal_o, off_ill});
    endtask

    task rd6(input logic [31:0] e [6]);
        for (int i = 0; i < 6; i++)
            req(12'hcc0 + 12'(i + i / 3), 5'h14, e[i], 3'b100);
    endtask

    task run(input logic [31:0] f, input logic [31:0] s, input int nj);
        int k;
        @(posedge clk_i);
        {go, from, stop} <= {1'b1, f, s};
        @(posedge clk_i);
        go <= 1'b0;
        k = 0;
        @(negedge clk_i);
        while (busy === 1'b1 && k < 200)
        begin
            @(negedge clk_i);
            k++;
        end
        if (k == 200)
        begin
            error_cnt++;
            conclude();
        end
        cmp(32'(nj), {24'h0, jumps});
    endtask

    // ****************
    // Scenarios
    // ****************
    task t_reset;
        for (int i = 0; i < 8; i++)
            req(12'hcc0 + 12'(i), 5'h14, 32'h0, {i % 4 != 3, 2'b00});
    endtask

    task t_trap;
        for (int i = 0; i < 8; i++)
            req(12'hcc0 + 12'(i), 5'h1c, 32'h0, {1'b0, i % 4 != 3, 1'b0});
        req(12'hcc0, 5'h10, 32'h0, 3'b000);
    endtask

    task t_setup;
        setup(2'h0, 1'b0, 1'b0, 32'h100, 12'h004, 32'h0, 12'h0);
        setup(2'h1, 1'b0, 1'b1, 32'h200, 12'hff0, 32'h0, 12'h0);
        setup(2'h2, 1'b0, 1'b0, 32'h0, 12'hfff, 32'h0, 12'h0);
        setup(2'h0, 1'b1, 1'b1, 32'h0, 12'h0, 32'h1234_5678, 12'h0);
        setup(2'h2, 1'b1, 1'b1, 32'h0, 12'h0, 32'h9, 12'h0);
        setup(2'h1, 1'b1, 1'b0, 32'h0, 12'h0, 32'ha00, 12'h0);
        rd6('{32'h110, 32'ha00, 32'hffff_ffff, 32'h1234_5678, 32'h1c0,
            32'h9});
        setup(2'h3, 1'b0, 1'b1, 32'h300, 12'h005, 32'h0, 12'h004);
        setup(2'h3, 1'b1, 1'b0, 32'h500, 12'h0, 32'h7, 12'hffc);
        rd6('{32'h504, 32'h4f0, 32'h7, 32'h304, 32'h310, 32'h5});
    endtask

    task t_loop;
        setup(2'h3, 1'b0, 1'b0, 32'h300, 12'h004, 32'h0, 12'h004);
        run(32'h304, 32'h310, 3);
        req(12'hcc2, 5'h14, 32'h0, 3'b100);
    endtask

    task t_nested;
        setup(2'h3, 1'b0, 1'b0, 32'h400, 12'h002, 32'h0, 12'h004);
        setup(2'h0, 1'b1, 1'b1, 32'h0, 12'h0, 32'h400, 12'h0);
        setup(2'h1, 1'b1, 1'b1, 32'h0, 12'h0, 32'h418, 12'h0);
        setup(2'h2, 1'b0, 1'b1, 32'h0, 12'h003, 32'h0, 12'h0);
        run(32'h400, 32'h418, 3);
        req(12'hcc6, 5'h14, 32'h0, 3'b100);
    endtask

    task t_ext;
        req(12'h000, 5'h06, 32'h0, 3'b001);
        req(12'h000, 5'h05, 32'h0, 3'b001);
    endtask

    initial
    begin
        {rst_n_i, en_i, setup_valid_i, setup_reg_form_i, setup_loop_i} = 5'h8;
        {csr_valid_i, csr_write_i, custom_valid_i, elw_valid_i, go} = 5'h0;
        {setup_op_i, setup_imm_i, setup_uimm_i, csr_addr_i} = 38'h0;
        {setup_pc_i, setup_rs1_i, from, stop} = 128'h0;
        error_cnt = 0;
        checks = 0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_trap();
        t_setup();
        t_loop();
        t_nested();
        t_ext();
        conclude();
    end
endmodule

bind zol_ctrl zol_assertions #(.CUSTOM_EXT_ENABLE(CUSTOM_EXT_ENABLE),
    .CLUSTER_EXT_ENABLE(CLUSTER_EXT_ENABLE)) zol_assertions_i (.*);
